// ---- core/otp_prog_pkg.sv ----
/*
 * Constants for the parallel program/verify port of the one-time code store:
 * mode codes, store sizes, signature locations, pulse count and timing.
 * Assumes a single 100 MHz clock; nothing else.
 */
package otp_prog_pkg;
    localparam int CODE_AW = 14;
    localparam int CODE_DEPTH = 16384;
    localparam int ENC_DEPTH = 64;
    localparam int ENC_AW = 6;
    localparam logic [5:0] ENC_LAST_ADDR = 6'h1F;
    localparam int PULSES_PER_WRITE = 5;
    localparam logic [15:0] SIG_MAKER_ADDR = 16'h0030;
    localparam logic [15:0] SIG_PART_ADDR = 16'h0031;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [2:0] SEC_RESET = 3'h0;
    localparam logic [7:0] DATA_RESET = 8'hFF;
    localparam int CLK_MHZ = 100;
    localparam int PULSE_MIN_US = 90;
    localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
    localparam int SIG_BIT_SB1 = 7;
    localparam int SIG_BIT_SB2 = 6;
    localparam int SIG_BIT_SB3 = 3;
    localparam int SIG_BIT_CLK6 = 4;

    typedef enum logic [3:0] {
        MODE_NONE    = 4'h0,
        MODE_SIG     = 4'h1,
        MODE_PGM     = 4'h2,
        MODE_VERIFY  = 4'h3,
        MODE_PGM_ENC = 4'h4,
        MODE_PGM_SB1 = 4'h5,
        MODE_PGM_SB2 = 4'h6,
        MODE_PGM_SB3 = 4'h7,
        MODE_PGM_X6  = 4'h8,
        MODE_VFY_X6  = 4'h9,
        MODE_VFY_SEC = 4'hA
    } mode_t;
endpackage

// ---- core/otp_mode_decode.sv ----
/*
 * Combinational decode of the programming mode pin levels.
 * Assumes pins are synchronous to clk and steady during an operation.
 */
`timescale 1ns/10ps
`default_nettype none
module otp_mode_decode (
    input  wire logic                 reset_active,
    input  wire logic                 code_fetch_strobe,
    input  wire logic                 p27,
    input  wire logic                 p26,
    input  wire logic                 mode_select_high,
    input  wire logic                 mode_select_low,
    input  wire logic                 p33,
    output otp_prog_pkg::mode_t       mode
);
    always_comb begin
        mode = otp_prog_pkg::MODE_NONE;
        if (reset_active && !code_fetch_strobe) begin
            unique case ({p27, p26, mode_select_high, mode_select_low})
                4'h0: mode = otp_prog_pkg::MODE_SIG;
                4'hB: mode = otp_prog_pkg::MODE_PGM;
                4'h3: mode = otp_prog_pkg::MODE_VERIFY;
                4'hA: mode = otp_prog_pkg::MODE_PGM_ENC;
                4'hF: mode = otp_prog_pkg::MODE_PGM_SB1;
                4'hC: mode = otp_prog_pkg::MODE_PGM_SB2;
                4'h5: mode = otp_prog_pkg::MODE_PGM_SB3;
                4'h2: mode = p33 ? otp_prog_pkg::MODE_VFY_SEC : otp_prog_pkg::MODE_PGM_X6;
                4'h1: mode = otp_prog_pkg::MODE_VFY_X6;
                default: mode = otp_prog_pkg::MODE_NONE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- core/otp_parallel_program_verify.sv ----
/*
 * Parallel program/verify port of the one-time code store: code array,
 * encryption table, security bits, encrypted verify, signature read.
 * Assumes the programmer holds pins steady per the mode levels and
 * supplies pull-ups on the data port (open-drain: drives low only).
 */
// Functional notes
// - a location is written after exactly five low program strobe pulses.
// - once table programmed, verify returns only encrypted data.
// - any security bit set blocks code and table writes.
// - unset security bits stay programmable after one is set.
// - code read-out only while security bits 2 and 3 are both clear.
// - verify drives addressed location onto port 0.
// - encrypted verify byte is XNOR of code byte and a table byte.
// - no path reads the encryption table itself.
// - signatures read like verify at 30h/31h with mode selects low.
// - device holds two signature bytes naming maker and part.
// - encryption bytes hold all ones before programming.
`timescale 1ns/10ps
`default_nettype none
module otp_parallel_program_verify #(
    parameter logic [7:0] SIG_MAKER = 8'hA5, // arbitrary value
    parameter logic [7:0] SIG_PART  = 8'h5A, // arbitrary value
    parameter int         PULSE_MIN = otp_prog_pkg::PULSE_MIN_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        reset_active,
    input  wire logic        code_fetch_strobe,
    input  wire logic        program_strobe,
    input  wire logic        program_voltage_input,
    input  wire logic [7:0]  addr_low,
    input  wire logic [7:0]  addr_high,
    input  wire logic        mode_select_high,
    input  wire logic        mode_select_low,
    input  wire logic        p33,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic      [7:0]  data_oe,
    output logic      [2:0]  security_bits,
    output logic             six_clock_mode
);
    otp_prog_pkg::mode_t mode;
    logic [7:0]  code_mem [otp_prog_pkg::CODE_DEPTH];
    logic [7:0]  enc_mem [otp_prog_pkg::ENC_DEPTH];
    logic        enc_programmed;
    logic [2:0]  pulse_count;
    logic [15:0] low_count;
    logic        strobe_prev;
    logic        pulse_ok;
    logic        commit;
    logic [15:0] addr;
    logic [7:0]  next_read;
    logic        read_mode;
    logic        write_mode;

    assign addr = {addr_high, addr_low};

    // port 2 bits 7:6 double as mode pins; address uses its low bits
    otp_mode_decode otp_mode_decode_inst (
        .reset_active      (reset_active),
        .code_fetch_strobe (code_fetch_strobe),
        .p27               (addr_high[7]),
        .p26               (addr_high[6]),
        .mode_select_high  (mode_select_high),
        .mode_select_low   (mode_select_low),
        .p33               (p33),
        .mode              (mode)
    );

    assign write_mode = (mode == otp_prog_pkg::MODE_PGM) || (mode == otp_prog_pkg::MODE_PGM_ENC)
                     || (mode == otp_prog_pkg::MODE_PGM_SB1) || (mode == otp_prog_pkg::MODE_PGM_SB2)
                     || (mode == otp_prog_pkg::MODE_PGM_SB3) || (mode == otp_prog_pkg::MODE_PGM_X6);
    assign read_mode = (mode == otp_prog_pkg::MODE_SIG) || (mode == otp_prog_pkg::MODE_VERIFY)
                    || (mode == otp_prog_pkg::MODE_VFY_X6) || (mode == otp_prog_pkg::MODE_VFY_SEC);

    // low-time counter: a pulse shorter than the minimum is not counted
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            low_count <= 16'h0000;
        end else if (program_strobe) begin
            low_count <= 16'h0000;
        end else if (low_count != 16'hFFFF) begin
            low_count <= low_count + 16'h0001;
        end
    end

    assign pulse_ok = (32'(low_count) >= PULSE_MIN);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobe_prev <= 1'b1;
        end else begin
            strobe_prev <= program_strobe;
        end
    end

    // count rising edges that end a valid low pulse; fifth one commits
    always_ff @(posedge clk) begin
        if (!rst_n || !write_mode || !program_voltage_input) begin
            pulse_count <= 3'h0;
        end else if (program_strobe && !strobe_prev && pulse_ok) begin
            if (pulse_count == 3'(otp_prog_pkg::PULSES_PER_WRITE - 1)) begin
                pulse_count <= 3'h0;
            end else begin
                pulse_count <= pulse_count + 3'h1;
            end
        end
    end

    assign commit = write_mode && program_voltage_input && program_strobe && !strobe_prev && pulse_ok
                 && (pulse_count == 3'(otp_prog_pkg::PULSES_PER_WRITE - 1));

    // one-time cells: programming only clears bits, so AND with new byte
    // limitation: rst_n stands in for the erased die, so it wipes both arrays
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < otp_prog_pkg::CODE_DEPTH; i++) begin
                code_mem[i] <= otp_prog_pkg::ERASED_BYTE;
            end
        end else if (commit && mode == otp_prog_pkg::MODE_PGM && security_bits == 3'h0) begin
            code_mem[addr[otp_prog_pkg::CODE_AW-1:0]] <= code_mem[addr[otp_prog_pkg::CODE_AW-1:0]] & data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int j = 0; j < otp_prog_pkg::ENC_DEPTH; j++) begin
                enc_mem[j] <= otp_prog_pkg::ERASED_BYTE;
            end
        end else if (commit && mode == otp_prog_pkg::MODE_PGM_ENC && security_bits == 3'h0
            && addr[otp_prog_pkg::ENC_AW-1:0] <= otp_prog_pkg::ENC_LAST_ADDR) begin
            enc_mem[addr[otp_prog_pkg::ENC_AW-1:0]] <= enc_mem[addr[otp_prog_pkg::ENC_AW-1:0]] & data_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enc_programmed <= 1'b0;
        end else if (commit && mode == otp_prog_pkg::MODE_PGM_ENC && security_bits == 3'h0
                     && data_in != otp_prog_pkg::ERASED_BYTE) begin
            enc_programmed <= 1'b1;
        end
    end

    // security bits: each settable regardless of the others
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            security_bits <= otp_prog_pkg::SEC_RESET;
        end else if (commit) begin
            if (mode == otp_prog_pkg::MODE_PGM_SB1) security_bits[0] <= 1'b1;
            if (mode == otp_prog_pkg::MODE_PGM_SB2) security_bits[1] <= 1'b1;
            if (mode == otp_prog_pkg::MODE_PGM_SB3) security_bits[2] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            six_clock_mode <= 1'b0;
        end else if (commit && mode == otp_prog_pkg::MODE_PGM_X6) begin
            six_clock_mode <= 1'b1;
        end
    end

    // read path; table bytes feed only the XNOR, never the port
    always_comb begin
        next_read = otp_prog_pkg::DATA_RESET;
        unique case (mode)
            otp_prog_pkg::MODE_SIG: begin
                if (addr == otp_prog_pkg::SIG_MAKER_ADDR) next_read = SIG_MAKER;
                else if (addr == otp_prog_pkg::SIG_PART_ADDR) next_read = SIG_PART;
            end
            otp_prog_pkg::MODE_VERIFY: begin
                if (!security_bits[1] && !security_bits[2]) begin
                    if (enc_programmed) begin
                        next_read = ~(code_mem[addr[otp_prog_pkg::CODE_AW-1:0]]
                                    ^ enc_mem[addr[otp_prog_pkg::ENC_AW-1:0]]);
                    end else begin
                        next_read = code_mem[addr[otp_prog_pkg::CODE_AW-1:0]];
                    end
                end
            end
            otp_prog_pkg::MODE_VFY_X6: next_read[otp_prog_pkg::SIG_BIT_CLK6] = !six_clock_mode;
            otp_prog_pkg::MODE_VFY_SEC: begin
                next_read[otp_prog_pkg::SIG_BIT_SB1] = !security_bits[0];
                next_read[otp_prog_pkg::SIG_BIT_SB2] = !security_bits[1];
                next_read[otp_prog_pkg::SIG_BIT_SB3] = !security_bits[2];
            end
            default: next_read = otp_prog_pkg::DATA_RESET;
        endcase
    end

    // open drain: pull low only for zero bits; pull-ups give the ones
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_out <= 8'h00;
            data_oe  <= 8'h00;
        end else begin
            data_out <= 8'h00;
            data_oe  <= read_mode ? ~next_read : 8'h00;
        end
    end
endmodule
`default_nettype wire

// ---- tb/otp_ppv_monitor.sv ----
/*
 * Port checker for the program/verify block, bound to its top module.
 * Assumes one clock, synchronous active-low reset, open-drain data port.
 */
`timescale 1ns/10ps
`default_nettype none
module otp_ppv_monitor #(
    parameter logic [7:0] SIG_MAKER = 8'hA5, // arbitrary value
    parameter logic [7:0] SIG_PART  = 8'h5A  // arbitrary value
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       reset_active,
    input wire logic       code_fetch_strobe,
    input wire logic       program_strobe,
    input wire logic       program_voltage_input,
    input wire logic [7:0] addr_low,
    input wire logic [7:0] addr_high,
    input wire logic       mode_select_high,
    input wire logic       mode_select_low,
    input wire logic       p33,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic [2:0] security_bits,
    input wire logic       six_clock_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic rd;
    logic vfy;
    logic sig;
    logic sb1_pins;
    logic sb2_pins;
    assign sb1_pins = addr_high[7:6] == 2'b11 && mode_select_high && mode_select_low;
    assign sb2_pins = addr_high[7:6] == 2'b11 && !mode_select_high && !mode_select_low;
    assign rd = reset_active && !code_fetch_strobe && program_strobe;
    assign vfy = rd && addr_high[7:6] == 2'b00 && mode_select_high && mode_select_low;
    assign sig = rd && addr_high == 8'h00 && !mode_select_high && !mode_select_low;
    drain_only_a: assert property (data_out == 8'h00)
        else $error("data port driven high");
    sec_sticky_a: assert property ((security_bits & $past(security_bits)) == $past(security_bits))
        else $error("security bit cleared");
    locked_verify_a: assert property (vfy && security_bits[2:1] != 2'b00 |=> data_oe == 8'h00)
        else $error("verify data shown while locked");
    idle_mode_a: assert property (!reset_active |=> data_oe == 8'h00)
        else $error("port driven outside reset");
    sec_needs_vpp_a: assert property (security_bits != $past(security_bits) |-> $past(program_voltage_input))
        else $error("security bit changed without vpp");
    maker_sig_a: assert property (sig && addr_low == 8'h30 ##1 sig && addr_low == 8'h30 |-> data_oe == ~SIG_MAKER)
        else $error("maker signature wrong");
    part_sig_a: assert property (sig && addr_low == 8'h31 ##1 sig && addr_low == 8'h31 |-> data_oe == ~SIG_PART)
        else $error("part signature wrong");
    sb1_mode_a: assert property ($rose(security_bits[0]) |-> $past(sb1_pins))
        else $error("first security bit set outside its mode");
    sb2_mode_a: assert property ($rose(security_bits[1]) |-> $past(sb2_pins))
        else $error("second security bit set outside its mode");
    sig_read_c: cover property (sig ##1 sig);
    locked_c: cover property (vfy && security_bits[1]);
    sb1_c: cover property ($rose(security_bits[0]));
endmodule
bind otp_parallel_program_verify otp_ppv_monitor #(
    .SIG_MAKER (SIG_MAKER),
    .SIG_PART  (SIG_PART)
) otp_ppv_monitor_inst (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .reset_active          (reset_active),
    .code_fetch_strobe     (code_fetch_strobe),
    .program_strobe        (program_strobe),
    .program_voltage_input (program_voltage_input),
    .addr_low              (addr_low),
    .addr_high             (addr_high),
    .mode_select_high      (mode_select_high),
    .mode_select_low       (mode_select_low),
    .p33                   (p33),
    .data_in               (data_in),
    .data_out              (data_out),
    .data_oe               (data_oe),
    .security_bits         (security_bits),
    .six_clock_mode        (six_clock_mode)
);
`default_nettype wire

// ---- tb/otp_programmer_pullup.sv ----
/*
 * Programmer side of the data port: pull-up resistors on every line.
 * Assumes oe high means the device pulls the line to data_out.
 */
`timescale 1ns/10ps
`default_nettype none
module otp_programmer_pullup (
    input  wire logic [7:0] data_oe,
    input  wire logic [7:0] data_out,
    output wire logic [7:0] port_level
);
    // released lines float up, never hold a stale value
    assign port_level = (data_oe & data_out) | ~data_oe;
endmodule
`default_nettype wire

// ---- tb/otp_parallel_program_verify_test.sv ----
/*
 * Testbench for the program/verify block with a pull-up programmer port.
 * Assumes a short pulse minimum so five pulses fit in a few cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module otp_parallel_program_verify_test;
    localparam logic [7:0] MAKER = 8'h96; // arbitrary value
    localparam logic [7:0] PART  = 8'h69; // arbitrary value
    localparam logic [3:0] PGM = 4'hB, VFY = 4'h3, ENC = 4'hA, SIG = 4'h0, SB1 = 4'hF, SB2 = 4'hC;
    localparam logic [3:0] V6 = 4'h1, P6 = 4'h2, SB3 = 4'h5;
    logic clk = 1'b0, rst_n = 1'b0, reset_active = 1'b1, code_fetch_strobe = 1'b0;
    logic program_strobe = 1'b1, program_voltage_input = 1'b1, p33 = 1'b0;
    logic mode_select_high = 1'b0, mode_select_low = 1'b0;
    logic [7:0] addr_low = 8'h00, addr_high = 8'h00, data_in = 8'hFF, data_out, data_oe;
    logic [2:0] security_bits;
    logic       six_clock_mode;
    wire logic [7:0] port_level;
    int fail_count = 0;
    int n_checks = 0;
    otp_parallel_program_verify #(
        .SIG_MAKER (MAKER),
        .SIG_PART  (PART),
        .PULSE_MIN (4)
    ) otp_parallel_program_verify_inst (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .reset_active          (reset_active),
        .code_fetch_strobe     (code_fetch_strobe),
        .program_strobe        (program_strobe),
        .program_voltage_input (program_voltage_input),
        .addr_low              (addr_low),
        .addr_high             (addr_high),
        .mode_select_high      (mode_select_high),
        .mode_select_low       (mode_select_low),
        .p33                   (p33),
        .data_in               (data_in),
        .data_out              (data_out),
        .data_oe               (data_oe),
        .security_bits         (security_bits),
        .six_clock_mode        (six_clock_mode)
    );
    otp_programmer_pullup otp_programmer_pullup_inst (.data_oe(data_oe), .data_out(data_out), .port_level(port_level));
    always #5 clk = ~clk;
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic pins(logic [3:0] m, logic [13:0] a);
        @(negedge clk);
        {addr_high, addr_low} = {m[3:2], a};
        {mode_select_high, mode_select_low} = m[1:0];
    endtask
    // pulse low beyond the minimum, then a high gap
    task automatic pulse(int n);
        repeat (n) begin
            @(negedge clk);
            program_strobe = 1'b0;
            repeat (6) @(negedge clk);
            program_strobe = 1'b1;
            repeat (3) @(negedge clk);
        end
    endtask
    task automatic prog(logic [3:0] m, logic [13:0] a, logic [7:0] d, int n);
        pins(m, a);
        data_in = d;
        pulse(n);
    endtask
    task automatic read(logic [3:0] m, logic [13:0] a, logic [7:0] exp, string what);
        pins(m, a);
        repeat (4) @(negedge clk);
        check(what, exp, port_level);
    endtask
    task automatic blank_and_signature();
        read(VFY, 14'h0123, 8'hFF, "blank byte");
        read(SIG, 14'h0030, MAKER, "maker code");
        read(SIG, 14'h0031, PART, "part code");
    endtask
    task automatic five_pulses();
        prog(PGM, 14'h0123, 8'h3C, 4);
        read(VFY, 14'h0123, 8'hFF, "after four pulses");
        pulse(5);
        read(VFY, 14'h0123, 8'hFF, "pulses in verify mode");
        prog(PGM, 14'h0123, 8'h3C, 5);
        read(VFY, 14'h0123, 8'h3C, "after five pulses");
        reset_active = 1'b0;
        read(VFY, 14'h0123, 8'hFF, "out of reset");
        reset_active = 1'b1;
    endtask
    task automatic encrypted();
        prog(PGM, 14'h0043, 8'h3C, 5);
        prog(ENC, 14'h0003, 8'hF0, 5);
        read(VFY, 14'h0043, ~(8'h3C ^ 8'hF0), "encrypted byte");
        read(VFY, 14'h0123, 8'h3C, "erased table entry");
        prog(ENC, 14'h0025, 8'h0F, 5);
        read(VFY, 14'h0025, 8'hFF, "table index past end");
    endtask
    task automatic security();
        prog(SB1, 14'h0000, 8'hFF, 5);
        check("security bits", 8'h01, {5'h00, security_bits});
        prog(PGM, 14'h0200, 8'h00, 5);
        read(VFY, 14'h0200, 8'hFF, "locked code write");
        prog(ENC, 14'h0003, 8'h0F, 5);
        read(VFY, 14'h0043, ~(8'h3C ^ 8'hF0), "locked table write");
        prog(SB2, 14'h0000, 8'hFF, 5);
        check("security bits", 8'h03, {5'h00, security_bits});
        read(VFY, 14'h0123, 8'hFF, "verify locked");
    endtask
    // clock-mode bit and security readout; bits read 0 once programmed
    task automatic clock_and_lock();
        p33 = 1'b1;
        read(V6, 14'h0000, 8'hFF, "twelve clock flag");
        read(P6, 14'h0000, 8'h3F, "security readout");
        p33 = 1'b0;
        prog(P6, 14'h0000, 8'hFF, 5);
        check("six clock mode", 8'h01, {7'h00, six_clock_mode});
        p33 = 1'b1;
        read(V6, 14'h0000, 8'hEF, "six clock flag");
        prog(SB3, 14'h0000, 8'hFF, 5);
        check("security bits", 8'h07, {5'h00, security_bits});
        read(P6, 14'h0000, 8'h37, "security readout");
        p33 = 1'b0;
    endtask
    initial begin
        #100000;
        fail_count++;
        conclude();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        blank_and_signature();
        five_pulses();
        encrypted();
        security();
        clock_and_lock();
        conclude();
    end
endmodule
`default_nettype wire
